// ### rtl/cto_pkg.sv
// shared constants, types and helpers of the counter and timer operators
package cto_pkg;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS   = 50;
	localparam int SCAN_PERIOD_NS  = 10_000_000;
	localparam int SCAN_CYCLES_DEF = SCAN_PERIOD_NS / CLK_PERIOD_NS;
	localparam int LONG_UNIT_NS    = 500_000_000;
	localparam int LONG_PRESCALE   = LONG_UNIT_NS / SCAN_PERIOD_NS;

	localparam logic [1:0] AUTO_PULSE_SCANS  = 2'h2;
	localparam logic [1:0] COMBO_PULSE_SCANS = 2'h1;
	localparam logic [1:0] DLINE_PULSE_SCANS = 2'h2;

	// time settings in units: 10 ms standard, 0.5 s long range
	localparam logic [16:0] TIME_MIN  = 17'h00001;
	localparam logic [16:0] TIME_MAX  = 17'h1ad06;
	localparam logic [16:0] CMP_MAX   = 17'h1acfc;
	localparam logic [16:0] TIME_KNEE = 17'h01770;
	localparam logic [16:0] TIME_STEP = 17'h0000a;
	localparam logic [16:0] CLK_MIN   = 17'h0000a;
	localparam logic [15:0] CNT_PRESET_MIN = 16'h0001;
	localparam logic [23:0] PCT_FULL  = 24'h000064;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] OFS_CNT_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CNT_PRESET = 8'h04;
	localparam logic [7:0] OFS_CNT_THRESH = 8'h08;
	localparam logic [7:0] OFS_TMR_CTRL   = 8'h0c;
	localparam logic [7:0] OFS_TMR_TIME   = 8'h10;
	localparam logic [7:0] OFS_TMR_THRESH = 8'h14;
	localparam logic [7:0] OFS_CLK_PERIOD = 8'h18;
	localparam logic [7:0] OFS_STATUS     = 8'h1c;
	localparam logic [7:0] OFS_CNT_VALUE  = 8'h20;
	localparam logic [7:0] OFS_TMR_VALUE  = 8'h24;

	// reset values
	localparam logic [3:0]  RST_CNT_CTRL   = 4'h0;
	localparam logic [15:0] RST_CNT_PRESET = 16'h0006;
	localparam logic [15:0] RST_CNT_THRESH = 16'h0003;
	localparam logic [5:0]  RST_TMR_CTRL   = 6'h08;
	localparam logic [16:0] RST_TMR_TIME   = 17'h00064;
	localparam logic [16:0] RST_TMR_THRESH = 17'h00032;
	localparam logic [16:0] RST_CLK_PERIOD = 17'h00064;

	// field positions
	localparam int CNTF_CLEAR_EN = 0;
	localparam int CNTF_MANUAL   = 1;
	localparam int CNTF_DOWN     = 2;
	localparam int CNTF_TWO_WAY  = 3;
	localparam int TMRF_KIND_LSB = 0;
	localparam int TMRF_RISING   = 3;
	localparam int TMRF_RETRIG   = 4;
	localparam int TMRF_LONG     = 5;
	localparam int STS_CNT_OUT   = 0;
	localparam int STS_CNT_CMP   = 1;
	localparam int STS_TMR_OUT   = 2;
	localparam int STS_TMR_CMP   = 3;
	localparam int STS_CLK_OUT   = 4;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [2:0] {
		TK_MONO    = 3'h0,
		TK_BOUNDED = 3'h1,
		TK_PASSING = 3'h2,
		TK_DELAY   = 3'h3,
		TK_DLINE   = 3'h4
	} cto_kind_t;

	typedef enum logic [1:0] {
		TP_IDLE    = 2'h0,
		TP_RUN     = 2'h1,
		TP_EXPIRED = 2'h3,
		TP_PULSE   = 2'h2
	} cto_phase_t;

	////////////////////////////////////////////////////////////////////////
	// clamp into range, coarse step above the knee (rounds down)
	function automatic logic [16:0] cto_qtime(
		input logic [31:0] v,
		input logic [16:0] lo,
		input logic [16:0] hi
	);
		logic [16:0] t;
		if (v < {15'h0000, lo})
			t = lo;
		else if (v > {15'h0000, hi})
			t = hi;
		else
			t = v[16:0];
		if (t > TIME_KNEE)
			t = t - (t % TIME_STEP);
		return t;
	endfunction

	// duty in percent; bits are 10,20,30,40,60,70,80 from lsb
	function automatic logic [6:0] cto_duty_pct(input logic [6:0] sel);
		logic [6:0] d;
		case (sel)
			7'h01:   d = 7'h0a;
			7'h02:   d = 7'h14;
			7'h04:   d = 7'h1e;
			7'h08:   d = 7'h28;
			7'h10:   d = 7'h3c;
			7'h20:   d = 7'h46;
			7'h40:   d = 7'h50;
			7'h41:   d = 7'h5a;
			default: d = 7'h32;
		endcase
		return d;
	endfunction

endpackage

// ### rtl/cto_pulse_counter.sv
`timescale 1ns/10ps
// pulse counter operator with its count comparator
module cto_pulse_counter
	import cto_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        scanTick,
	// configuration
	input  wire logic        clearEnable,
	input  wire logic        manualMode,
	input  wire logic        countDown,
	input  wire logic        twoWay,
	input  wire logic [15:0] preset,
	input  wire logic [15:0] threshold,
	// operator pins
	input  wire logic        pulseIn,
	input  wire logic        clearIn,
	output logic             cntOut,
	output logic             cmpOut,
	output logic [15:0]      countValue
);

	logic [15:0] up_ff;
	logic        prev_ff;
	logic        held_ff;
	logic [1:0]  pulse_ff;
	logic [15:0] value_ff;
	logic        cmp_ff;
	logic [2:0]  hiScans_ff;
	logic        manual;
	logic        combined;
	logic        clearHit;
	logic        edgeHit;
	logic        reached;
	logic [15:0] upNext;
	logic [15:0] valueNow;

	assign manual   = clearEnable & manualMode;
	assign combined = clearEnable & ~manualMode;
	assign clearHit = scanTick & clearEnable & clearIn;
	assign edgeHit  = scanTick & (pulseIn ^ prev_ff) & (twoWay | pulseIn);
	assign upNext   = up_ff + 16'h0001;
	// >= so that lowering the preset mid-count still terminates
	assign reached  = upNext >= preset;

	always_ff @(posedge sys_clk)
		if (reset)
			prev_ff <= 1'b0;
		else if (scanTick)
			prev_ff <= pulseIn;

	always_ff @(posedge sys_clk)
		if (reset)
			up_ff <= 16'h0000;
		else if (clearHit)
			up_ff <= 16'h0000;
		else if (edgeHit && !held_ff)
			up_ff <= (reached && !manual) ? 16'h0000 : upNext;

	always_ff @(posedge sys_clk)
		if (reset)
			held_ff <= 1'b0;
		else if (clearHit)
			held_ff <= 1'b0;
		else if (edgeHit && reached && manual)
			held_ff <= 1'b1;

	always_ff @(posedge sys_clk)
		if (reset)
			pulse_ff <= 2'h0;
		else if (edgeHit && reached && !manual && !clearHit)
			pulse_ff <= combined ? COMBO_PULSE_SCANS : AUTO_PULSE_SCANS;
		else if (scanTick && pulse_ff != 2'h0)
			pulse_ff <= pulse_ff - 2'h1;

	assign cntOut = held_ff | (pulse_ff != 2'h0);

	////////////////////////////////////////////////////////////////////////
	// count value and comparator
	assign valueNow = countDown ? preset - up_ff : up_ff;

	always_ff @(posedge sys_clk)
		if (reset)
		begin
			value_ff <= 16'h0000;
			cmp_ff   <= 1'b0;
		end
		else
		begin
			value_ff <= valueNow;
			cmp_ff   <= valueNow >= threshold;
		end

	assign countValue = value_ff;
	assign cmpOut     = cmp_ff;

	////////////////////////////////////////////////////////////////////////
	// checks
	always_ff @(posedge sys_clk)
		if (reset || !cntOut)
			hiScans_ff <= 3'h0;
		else if (scanTick)
			hiScans_ff <= hiScans_ff + 3'h1;

	a_auto_pulse_len: assert property (
		@(posedge sys_clk) disable iff (reset)
		($fell(cntOut) && !clearEnable && $stable(clearEnable))
		|-> hiScans_ff == 3'h2)
		else $error("automatic pulse not two scans long");

	a_manual_hold: assert property (
		@(posedge sys_clk) disable iff (reset)
		(manual && cntOut && !clearIn && $stable(manualMode)
		&& $stable(clearEnable)) |=> cntOut)
		else $error("manual output dropped without clear");

	a_clear_zero: assert property (
		@(posedge sys_clk) disable iff (reset)
		(clearHit && !countDown) ##1 !countDown |=> countValue == 16'h0000)
		else $error("clear did not return count to zero");

	a_cmp_level: assert property (
		@(posedge sys_clk) disable iff (reset)
		$stable(threshold) && !$past(reset)
		|-> cmpOut == (countValue >= threshold))
		else $error("count comparator level wrong");

endmodule

// ### rtl/cto_clock_gen.sv
`timescale 1ns/10ps
// gated square wave generator with selectable duty
module cto_clock_gen
	import cto_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        scanTick,
	// configuration
	input  wire logic [16:0] period,
	// operator pins
	input  wire logic        gateIn,
	input  wire logic [6:0]  dutySel,
	output logic             clkOut
);

	logic [16:0] phase_ff;
	logic        out_ff;
	logic [6:0]  duty;
	logic [23:0] prod;
	logic [16:0] highUnits;
	logic [16:0] phaseInc;

	// illegal selections fall back to half duty
	assign duty      = cto_duty_pct(dutySel);
	assign prod      = {7'h00, period} * {17'h00000, duty};
	assign highUnits = 17'(prod / PCT_FULL);
	assign phaseInc  = phase_ff + 17'h00001;

	always_ff @(posedge sys_clk)
		if (reset)
		begin
			phase_ff <= 17'h00000;
			out_ff   <= 1'b0;
		end
		else if (scanTick)
		begin
			if (!gateIn)
			begin
				phase_ff <= 17'h00000;
				out_ff   <= 1'b0;
			end
			else
			begin
				phase_ff <= (phaseInc >= period) ? 17'h00000 : phaseInc;
				out_ff   <= phase_ff < highUnits;
			end
		end

	assign clkOut = out_ff;

	a_gate_low: assert property (
		@(posedge sys_clk) disable iff (reset)
		(scanTick && !gateIn) |=> !clkOut ##1 (!clkOut || scanTick))
		else $error("wave running with gate low");

endmodule

// ### rtl/cto_operators.sv
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
// counter and timer operators behind an apb register file
////////////////////////////////////////////////////////////////////////////
module cto_operators
	import cto_pkg::*;
#(
	parameter int SCAN_CYCLES = SCAN_CYCLES_DEF
)
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// counter operator
	input  wire logic        cntPulseIn,
	input  wire logic        cntClearIn,
	output logic             cntOut,
	output logic             cntCmpOut,
	output logic [15:0]      cntValue,
	// timer operator
	input  wire logic        tmrIn,
	output logic             tmrOut,
	output logic             tmrCmpOut,
	output logic [16:0]      tmrValue,
	// clock generator
	input  wire logic        clkGateIn,
	input  wire logic [6:0]  clkDutySel,
	output logic             clkWaveOut
);

	localparam logic [23:0] SCAN_LAST = 24'(SCAN_CYCLES - 1);
	localparam logic [5:0]  PRE_LAST  = 6'(LONG_PRESCALE - 1);

	logic [23:0] scanDiv_ff;
	logic        scanTick_ff;
	logic [3:0]  cntCtrl_ff;
	logic [15:0] cntPreset_ff;
	logic [15:0] cntThresh_ff;
	logic [5:0]  tmrCtrl_ff;
	logic [16:0] tmrTime_ff;
	logic [16:0] tmrThresh_ff;
	logic [16:0] clkPeriod_ff;
	logic [31:0] prdata_ff;
	logic        wrEn;
	logic        addrHit;
	logic [31:0] rdMux;

	cto_phase_t  phase_ff;
	cto_phase_t  nxtPhase;
	cto_kind_t   tmrKind;
	logic [16:0] remain_ff;
	logic [5:0]  pre_ff;
	logic [1:0]  pulse_ff;
	logic        tmrPrev_ff;
	logic        tmrY_ff;
	logic [16:0] tmrValue_ff;
	logic        tmrCmp_ff;
	logic [16:0] hiUnits_ff;
	logic        nxtY;
	logic        rising;
	logic        retrig;
	logic        longRange;
	logic        rose;
	logic        fell;
	logic        chg;
	logic        edgeOn;
	logic        edgeOff;
	logic        xLvl;
	logic        unitTick;
	logic        running;
	logic        expire;
	logic        start;
	logic        clr;
	logic        nxtRun;
	logic        invertOut;
	logic [16:0] elapsed;

	////////////////////////////////////////////////////////////////////////
	// scan cycle time base
	always_ff @(posedge sys_clk)
		if (reset)
		begin
			scanDiv_ff  <= 24'h000000;
			scanTick_ff <= 1'b0;
		end
		else if (scanDiv_ff == SCAN_LAST)
		begin
			scanDiv_ff  <= 24'h000000;
			scanTick_ff <= 1'b1;
		end
		else
		begin
			scanDiv_ff  <= scanDiv_ff + 24'h000001;
			scanTick_ff <= 1'b0;
		end

	////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states
	assign wrEn    = psel & penable & pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addrHit;
	assign prdata  = prdata_ff;

	always_comb
	begin
		rdMux   = 32'h00000000;
		addrHit = 1'b1;
		case (paddr)
			OFS_CNT_CTRL:   rdMux[3:0]  = cntCtrl_ff;
			OFS_CNT_PRESET: rdMux[15:0] = cntPreset_ff;
			OFS_CNT_THRESH: rdMux[15:0] = cntThresh_ff;
			OFS_TMR_CTRL:   rdMux[5:0]  = tmrCtrl_ff;
			OFS_TMR_TIME:   rdMux[16:0] = tmrTime_ff;
			OFS_TMR_THRESH: rdMux[16:0] = tmrThresh_ff;
			OFS_CLK_PERIOD: rdMux[16:0] = clkPeriod_ff;
			OFS_STATUS:
			begin
				rdMux[STS_CNT_OUT] = cntOut;
				rdMux[STS_CNT_CMP] = cntCmpOut;
				rdMux[STS_TMR_OUT] = tmrOut;
				rdMux[STS_TMR_CMP] = tmrCmpOut;
				rdMux[STS_CLK_OUT] = clkWaveOut;
			end
			OFS_CNT_VALUE:  rdMux[15:0] = cntValue;
			OFS_TMR_VALUE:  rdMux[16:0] = tmrValue;
			default:        addrHit     = 1'b0;
		endcase
	end

	// read data captured in the setup cycle, stable through access
	always_ff @(posedge sys_clk)
		if (reset)
			prdata_ff <= 32'h00000000;
		else if (psel && !penable)
			prdata_ff <= rdMux;

	always_ff @(posedge sys_clk)
		if (reset)
		begin
			cntCtrl_ff   <= RST_CNT_CTRL;
			cntPreset_ff <= RST_CNT_PRESET;
			cntThresh_ff <= RST_CNT_THRESH;
		end
		else if (wrEn)
		begin
			if (paddr == OFS_CNT_CTRL)
				cntCtrl_ff <= pwdata[3:0];
			if (paddr == OFS_CNT_PRESET)
				cntPreset_ff <= (pwdata[15:0] < CNT_PRESET_MIN) ?
					CNT_PRESET_MIN : pwdata[15:0];
			if (paddr == OFS_CNT_THRESH)
				cntThresh_ff <= pwdata[15:0];
		end

	// writes are clamped and stepped, readback shows the applied time
	always_ff @(posedge sys_clk)
		if (reset)
		begin
			tmrCtrl_ff   <= RST_TMR_CTRL;
			tmrTime_ff   <= RST_TMR_TIME;
			tmrThresh_ff <= RST_TMR_THRESH;
			clkPeriod_ff <= RST_CLK_PERIOD;
		end
		else if (wrEn)
		begin
			if (paddr == OFS_TMR_CTRL)
				tmrCtrl_ff <= pwdata[5:0];
			if (paddr == OFS_TMR_TIME)
				tmrTime_ff <= cto_qtime(pwdata, TIME_MIN, TIME_MAX);
			if (paddr == OFS_TMR_THRESH)
				tmrThresh_ff <= cto_qtime(pwdata, TIME_MIN, CMP_MAX);
			if (paddr == OFS_CLK_PERIOD)
				clkPeriod_ff <= cto_qtime(pwdata, CLK_MIN, TIME_MAX);
		end

	////////////////////////////////////////////////////////////////////////
	// counter and clock generator
	cto_pulse_counter u_counter (
		.sys_clk     (sys_clk),
		.reset       (reset),
		.scanTick    (scanTick_ff),
		.clearEnable (cntCtrl_ff[CNTF_CLEAR_EN]),
		.manualMode  (cntCtrl_ff[CNTF_MANUAL]),
		.countDown   (cntCtrl_ff[CNTF_DOWN]),
		.twoWay      (cntCtrl_ff[CNTF_TWO_WAY]),
		.preset      (cntPreset_ff),
		.threshold   (cntThresh_ff),
		.pulseIn     (cntPulseIn),
		.clearIn     (cntClearIn),
		.cntOut      (cntOut),
		.cmpOut      (cntCmpOut),
		.countValue  (cntValue)
	);

	cto_clock_gen u_clock_gen (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.scanTick (scanTick_ff),
		.period   (clkPeriod_ff),
		.gateIn   (clkGateIn),
		.dutySel  (clkDutySel),
		.clkOut   (clkWaveOut)
	);

	////////////////////////////////////////////////////////////////////////
	// timer operator: edges and time units
	assign tmrKind   = cto_kind_t'(tmrCtrl_ff[TMRF_KIND_LSB +: 3]);
	assign rising    = tmrCtrl_ff[TMRF_RISING];
	assign retrig    = tmrCtrl_ff[TMRF_RETRIG];
	assign longRange = tmrCtrl_ff[TMRF_LONG];
	assign rose      = scanTick_ff & tmrIn & ~tmrPrev_ff;
	assign fell      = scanTick_ff & ~tmrIn & tmrPrev_ff;
	assign chg       = rose | fell;
	assign edgeOn    = rising ? rose : fell;
	assign edgeOff   = rising ? fell : rose;
	assign xLvl      = rising ? tmrIn : ~tmrIn;
	assign unitTick  = scanTick_ff & (~longRange | pre_ff == PRE_LAST);
	assign running   = phase_ff == TP_RUN;
	assign expire    = unitTick & running & (remain_ff == 17'h00001);
	assign nxtRun    = nxtPhase == TP_RUN;
	assign invertOut = ~rising & (tmrKind == TK_MONO || tmrKind == TK_BOUNDED);

	always_comb
	begin
		start = 1'b0;
		clr   = 1'b0;
		case (tmrKind)
			TK_MONO, TK_BOUNDED:
				start = edgeOn | (retrig & chg);
			TK_PASSING:
			begin
				start = rose;
				clr   = fell & ~retrig;
			end
			TK_DELAY:
			begin
				start = edgeOn | (retrig & chg);
				clr   = edgeOff & ~retrig;
			end
			// a second fall while running restarts the line
			TK_DLINE:
				start = fell;
			default:
			begin
				start = 1'b0;
				clr   = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		nxtPhase = phase_ff;
		if (start)
			nxtPhase = TP_RUN;
		else if (clr)
			nxtPhase = TP_IDLE;
		else
			case (phase_ff)
				TP_IDLE:
					nxtPhase = TP_IDLE;
				TP_RUN:
					if (expire)
						nxtPhase = (tmrKind == TK_DLINE && tmrIn) ?
							TP_PULSE : TP_EXPIRED;
				TP_EXPIRED:
					nxtPhase = TP_EXPIRED;
				TP_PULSE:
					if (scanTick_ff && pulse_ff == 2'h1)
						nxtPhase = TP_IDLE;
				default:
					nxtPhase = TP_IDLE;
			endcase
	end

	always_comb
	begin
		nxtY = tmrY_ff;
		case (tmrKind)
			TK_MONO:
				nxtY = nxtRun | (tmrY_ff & xLvl);
			TK_BOUNDED:
				nxtY = nxtRun;
			TK_PASSING:
				nxtY = retrig ? nxtRun : (tmrIn & nxtRun);
			TK_DELAY:
				if (rising)
					nxtY = tmrIn & (tmrY_ff | expire);
				else
					nxtY = rose | (tmrY_ff & ~(expire & ~tmrIn));
			TK_DLINE:
				if (nxtRun)
					nxtY = 1'b1;
				else
					nxtY = (nxtPhase == TP_PULSE) ? 1'b0 : tmrIn;
			default:
				nxtY = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// timer operator: state
	always_ff @(posedge sys_clk)
		if (reset)
			phase_ff <= TP_IDLE;
		else
			phase_ff <= nxtPhase;

	always_ff @(posedge sys_clk)
		if (reset)
			remain_ff <= 17'h00000;
		else if (start)
			remain_ff <= tmrTime_ff;
		else if (unitTick && running && remain_ff != 17'h00000)
			remain_ff <= remain_ff - 17'h00001;

	// prescaler restarts with the timer so long times are not short
	always_ff @(posedge sys_clk)
		if (reset || start)
			pre_ff <= 6'h00;
		else if (scanTick_ff)
			pre_ff <= (pre_ff == PRE_LAST) ? 6'h00 : pre_ff + 6'h01;

	always_ff @(posedge sys_clk)
		if (reset)
			pulse_ff <= 2'h0;
		else if (nxtPhase == TP_PULSE && phase_ff != TP_PULSE)
			pulse_ff <= DLINE_PULSE_SCANS;
		else if (scanTick_ff && pulse_ff != 2'h0)
			pulse_ff <= pulse_ff - 2'h1;

	always_ff @(posedge sys_clk)
		if (reset)
		begin
			tmrPrev_ff <= 1'b0;
			tmrY_ff    <= 1'b0;
		end
		else if (scanTick_ff)
		begin
			tmrPrev_ff <= tmrIn;
			tmrY_ff    <= nxtY;
		end

	assign tmrOut = tmrY_ff ^ invertOut;

	always_comb
		case (phase_ff)
			TP_RUN:     elapsed = tmrTime_ff - remain_ff;
			TP_EXPIRED: elapsed = tmrTime_ff;
			default:    elapsed = 17'h00000;
		endcase

	always_ff @(posedge sys_clk)
		if (reset)
		begin
			tmrValue_ff <= 17'h00000;
			tmrCmp_ff   <= 1'b0;
		end
		else
		begin
			tmrValue_ff <= elapsed;
			tmrCmp_ff   <= elapsed >= tmrThresh_ff;
		end

	assign tmrValue  = tmrValue_ff;
	assign tmrCmpOut = tmrCmp_ff;

	////////////////////////////////////////////////////////////////////////
	// checks
	always_ff @(posedge sys_clk)
		if (reset || !tmrY_ff)
			hiUnits_ff <= 17'h00000;
		else if (unitTick)
			hiUnits_ff <= hiUnits_ff + 17'h00001;

	a_bounded_limit: assert property (
		@(posedge sys_clk) disable iff (reset)
		(tmrKind == TK_BOUNDED && !retrig && $stable(tmrTime_ff))
		|-> hiUnits_ff <= tmrTime_ff)
		else $error("bounded one-shot held past set time");

	a_pass_follow: assert property (
		@(posedge sys_clk) disable iff (reset)
		(tmrKind == TK_PASSING && !retrig && scanTick_ff && !tmrIn)
		|=> !tmrOut)
		else $error("passing contact high with input low");

	a_delay_rise: assert property (
		@(posedge sys_clk) disable iff (reset)
		(tmrKind == TK_DELAY && rising && scanTick_ff && !tmrIn)
		|=> !tmrOut)
		else $error("rising delay high with input low");

	a_delay_inv: assert property (
		@(posedge sys_clk) disable iff (reset)
		(tmrKind == TK_DELAY && !rising && rose) |=> tmrOut)
		else $error("inverted delay missed rising edge");

	a_dline_pulse: assert property (
		@(posedge sys_clk) disable iff (reset)
		(tmrKind == TK_DLINE && expire && tmrIn)
		|=> !tmrOut && phase_ff == TP_PULSE)
		else $error("delay line skipped its low pulse");

	a_tcmp_thresh: assert property (
		@(posedge sys_clk) disable iff (reset)
		$stable(tmrThresh_ff) && !$past(reset)
		|-> tmrCmpOut == (tmrValue >= tmrThresh_ff))
		else $error("timer comparator level wrong");

	a_preset_write: assert property (
		@(posedge sys_clk) disable iff (reset)
		(wrEn && paddr == OFS_CNT_PRESET && pwdata[15:0] != 16'h0000)
		|=> cntPreset_ff == $past(pwdata[15:0]))
		else $error("preset write not applied");

endmodule

// ### dv/cto_far_logic.sv
`timescale 1ns/10ps
// upstream operator logic driving the operator inputs
module cto_far_logic
(
	// clock
	input  wire logic sys_clk,
	// operator levels
	output logic       pulseLvl,
	output logic       clearLvl,
	output logic       tmrLvl,
	output logic       gateLvl,
	output logic [6:0] dutyLvl
);
	initial
	begin
		{pulseLvl, clearLvl, tmrLvl, gateLvl, dutyLvl} = 11'h000;
	end

	// a level stands two scans, so no tick misses it
	task automatic drive(input int s, input logic v);
		case (s)
			0: pulseLvl <= v;
			1: clearLvl <= v;
			2: tmrLvl <= v;
			default: gateLvl <= v;
		endcase
		repeat (8) @(posedge sys_clk);
	endtask

	// one duty input at most, or the 10/80 pair
	task automatic duty(input int p);
		dutyLvl <= (p == 8) ? 7'h41 : 7'((1 << p) >> 1);
	endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/10ps
// self-checking bench of the counter and timer operators
module testbench;
	import cto_pkg::*;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, cntOut, cntCmpOut, tmrOut, tmrCmpOut;
	logic        clkWaveOut, pulseLvl, clearLvl, tmrLvl, gateLvl, err;
	logic [6:0]  dutyLvl;
	logic [15:0] cntValue;
	logic [16:0] tmrValue;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          hi, p;

	always #25 sys_clk = ~sys_clk;

	cto_far_logic u_far (.sys_clk(sys_clk), .pulseLvl(pulseLvl),
		.clearLvl(clearLvl), .tmrLvl(tmrLvl), .gateLvl(gateLvl),
		.dutyLvl(dutyLvl));

	cto_operators #(.SCAN_CYCLES(4)) u_dut (.sys_clk(sys_clk),
		.reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cntPulseIn(pulseLvl), .cntClearIn(clearLvl),
		.cntOut(cntOut), .cntCmpOut(cntCmpOut), .cntValue(cntValue),
		.tmrIn(tmrLvl), .tmrOut(tmrOut), .tmrCmpOut(tmrCmpOut),
		.tmrValue(tmrValue), .clkGateIn(gateLvl), .clkDutySel(dutyLvl),
		.clkWaveOut(clkWaveOut));

	////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s exp %0h got %0h", n, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input int d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge sys_clk);
			i++;
		end
		while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1)
		begin
			error_cnt++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	// clocks with the chosen output high in a window of n clocks
	task automatic meas(input int s, input int n);
		hi = 0;
		repeat (n)
		begin
			@(posedge sys_clk);
			hi += (s == 0) ? int'(cntOut === 1'b1) :
				(s == 1) ? int'(tmrOut === 1'b1) : int'(clkWaveOut === 1'b1);
		end
	endtask

	initial
	begin
		p = $urandom(32'h2ac88662);
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		apb(1'b0, OFS_CNT_PRESET, 0);
		chk("preset", 6, rd);
		apb(1'b0, 8'h28, 0);
		chk("unmapped", 1, err);
		apb(1'b1, OFS_CNT_CTRL, 4);
		apb(1'b1, OFS_CNT_PRESET, 2);
		apb(1'b1, OFS_CNT_THRESH, 1);
		u_far.drive(0, 1'b1);
		u_far.drive(0, 1'b0);
		chk("down value", 2 - 1, cntValue);
		chk("cmp eq", 1, cntCmpOut);
		fork
			u_far.drive(0, 1'b1);
			meas(0, 40);
		join
		chk("auto pulse", 2 * 4, hi);
		apb(1'b1, OFS_CNT_CTRL, 8);
		apb(1'b1, OFS_CNT_PRESET, 6);
		apb(1'b1, OFS_CNT_THRESH, 3);
		u_far.drive(0, 1'b0);
		u_far.drive(0, 1'b1);
		chk("two-way", 2, cntValue);
		chk("cmp low", 0, cntCmpOut);
		u_far.drive(0, 1'b0);
		chk("cmp high", 1, cntCmpOut);
		apb(1'b1, OFS_CNT_CTRL, 3);
		apb(1'b1, OFS_CNT_PRESET, 4);
		u_far.drive(0, 1'b1);
		meas(0, 40);
		chk("manual hold", 40, hi);
		u_far.drive(1, 1'b1);
		chk("manual clear", 0, cntOut);
		chk("cleared", 0, cntValue);
		u_far.drive(1, 1'b0);
		apb(1'b1, OFS_CNT_CTRL, 1);
		apb(1'b1, OFS_CNT_PRESET, 1);
		u_far.drive(0, 1'b0);
		fork
			u_far.drive(0, 1'b1);
			meas(0, 40);
		join
		chk("combined pulse", 4, hi);
		apb(1'b1, OFS_TMR_TIME, 2);
		apb(1'b1, OFS_TMR_CTRL, 9);
		fork
			u_far.drive(2, 1'b1);
			meas(1, 40);
		join
		chk("bounded", 2 * 4, hi);
		u_far.drive(2, 1'b0);
		apb(1'b1, OFS_TMR_TIME, 6005);
		apb(1'b0, OFS_TMR_TIME, 0);
		chk("time step", 6000, rd);
		apb(1'b1, OFS_TMR_CTRL, 11);
		apb(1'b1, OFS_TMR_TIME, 2);
		u_far.drive(2, 1'b1);
		chk("delay early", 0, tmrOut);
		repeat (8) @(posedge sys_clk);
		chk("delay out", 1, tmrOut);
		chk("timer value", 2, tmrValue);
		u_far.drive(2, 1'b0);
		chk("delay drop", 0, tmrOut);
		apb(1'b1, OFS_TMR_CTRL, 2);
		u_far.drive(2, 1'b1);
		chk("pass follow", 1, tmrOut);
		repeat (8) @(posedge sys_clk);
		chk("pass cut", 0, tmrOut);
		u_far.drive(2, 1'b0);
		apb(1'b1, OFS_TMR_CTRL, 4);
		apb(1'b1, OFS_TMR_TIME, 4);
		u_far.drive(2, 1'b1);
		u_far.drive(2, 1'b0);
		u_far.drive(2, 1'b1);
		chk("line held", 1, tmrOut);
		meas(1, 16);
		chk("line pulse", 16 - 2 * 4, hi);
		apb(1'b1, OFS_TMR_CTRL, 43);
		apb(1'b1, OFS_TMR_TIME, 1);
		apb(1'b1, OFS_TMR_THRESH, 1);
		u_far.drive(2, 1'b0);
		u_far.drive(2, 1'b1);
		chk("long early", 0, tmrOut);
		chk("tcmp early", 0, tmrCmpOut);
		repeat (200) @(posedge sys_clk);
		chk("long out", 1, tmrOut);
		chk("tcmp high", 1, tmrCmpOut);
		apb(1'b1, OFS_TMR_CTRL, 0);
		u_far.drive(2, 1'b0);
		repeat (8) @(posedge sys_clk);
		chk("mono extend", 0, tmrOut);
		u_far.drive(2, 1'b1);
		chk("mono idle", 1, tmrOut);
		apb(1'b1, OFS_CLK_PERIOD, 10);
		u_far.drive(3, 1'b1);
		repeat (3)
		begin
			p = $urandom_range(8, 0);
			u_far.duty(p);
			repeat (80) @(posedge sys_clk);
			meas(2, 40);
			p = (p == 0) ? 50 : (p < 5) ? p * 10 : (p < 8) ? p * 10 + 10 : 90;
			chk("duty", 4 * p / 10, hi);
		end
		u_far.drive(3, 1'b0);
		chk("gate low", 0, clkWaveOut);
		test_done();
	end

	// a hang counts as a mismatch
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		test_done();
	end
endmodule
